// ---- serial_port_defs.svh ----
// How it works
// R1 - In sleep the receiver gets no baud ticks and never runs normal reception; here ticks still arrive and rx_hold keeps it idle.
// R2 - Wake-on-low acts only in asynchronous mode, never in synchronous mode.
// R3 - Wake-on-low set suppresses reception; port idles and watches the line.
// R4 - Wake event is a falling edge on the serial input while wake-on-low is set.
// R5 - Wake event sets receive-pending; sleep sets it without the clocked path.
// R6 - Reading the receive data register clears receive-pending.
// R7 - Wake-on-low clears itself on the next rising edge; receiver returns to idle.
// R8 - A non-zero character's first low time is the wake event; rest is a fragment.
// R9 - Remote wake character is all zeros, at least ten bit times.
// R10 - Software checks receiver idle before setting wake-on-low.
// R11 - A break is a start bit, twelve zero bits, then a stop bit.
// R12 - Break request plus transmit enable: a data write starts a break of zeros.
// R13 - Break request clears after the break stop bit; a preloaded byte follows.
// R14 - Shifter-empty reports activity during a break as for normal characters.
// R15 - LIN header: break, dummy write, then 55h sent after the break.
// R16 - Transmit-buffer-empty rises when the data register empties.
// R17 - Received break: pending set, framing error set, data equals zero.
// R18 - Wake-based detection: event on the break, then a second event for next byte.
// R19 - Software may set auto-baud before sleep with either detection method.
// R20 - Synchronous mode is half-duplex, master or slave clocked; sync_mode here has no clock, it only holds the receiver idle and blocks wake.
// R21 - Synchronous transfers have no start or stop bits; the transmitter still sends both with sync_mode set.
// R22 - With wake-on-low and auto-baud, measurement applies to the byte after break.
// R23 - The serial input passes a two-stage synchroniser before edge detection.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define BREAK_ZERO_BITS 4'hC
`define DATA_BITS 4'h8
`define SAMPLE_MID 4'h8
`define OVERSAMPLE_LAST 4'hF
`endif

// ---- serial_port_pkg.sv ----
package serial_port_pkg;
	typedef struct packed {
		logic wake_on_low_enable;
		logic autobaud_enable;
		logic sync_mode;
		logic break_send_request;
		logic transmit_enable_bit;
	} ctrl_t;
	typedef struct packed {
		logic receive_pending_flag;
		logic framing_error_flag;
		logic receiver_idle_flag;
		logic shifter_empty_flag;
		logic transmit_buffer_empty_flag;
		logic break_received;
	} stat_t;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} tx_state_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} rx_state_t;
endpackage

// ---- serial_port_unit.sv ----
// Chosen here: a separate strobe per register (ctrl_wr, tx_wr, rx_rd) with no address port.
`timescale 1ns/100ps
`include "serial_port_defs.svh"
module serial_port_unit (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic baud_tick,
	input wire logic sleep_mode,
	input wire logic serial_in_line,
	input wire serial_port_pkg::ctrl_t ctrl_wr_data,
	input wire logic ctrl_wr,
	input wire logic [7:0] tx_wr_data,
	input wire logic tx_wr,
	input wire logic rx_rd,
	output logic [7:0] receive_data_reg,
	output serial_port_pkg::ctrl_t ctrl_reg,
	output serial_port_pkg::stat_t stat_reg,
	output logic serial_out_line,
	output logic wake_event_reg,
	output logic autobaud_start_reg
);
	import serial_port_pkg::*;

	logic rst_s1_reg, rst_reg;
	logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
	logic rx_fall, rx_rise;
	logic [7:0] transmit_data_reg, shift_reg, rx_shift_reg;
	logic tx_full_reg, tx_is_break_reg;
	logic [3:0] tx_tick_cnt_reg, tx_bit_cnt_reg, rx_tick_cnt_reg, rx_bit_cnt_reg;
	logic wake_pending_reg, async_wake_reg, async_seen_reg, async_seen_s_reg, async_seen_d_reg;
	logic await_second_reg;
	tx_state_t tx_state_reg;
	rx_state_t rx_state_reg;
	logic rx_done, rx_frame_ok, tx_load, tx_done;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_reg <= rst_s1_reg;
		end
	end

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_s1_reg <= serial_in_line; // R23
			rx_s2_reg <= rx_s1_reg; // R23
			rx_prev_reg <= rx_s2_reg;
		end
	end
	assign rx_fall = rx_prev_reg & ~rx_s2_reg;
	assign rx_rise = ~rx_prev_reg & rx_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// Sleep path: line falling edge captured without the system clock
	always_ff @(negedge serial_in_line or negedge rst_reg) begin
		if (!rst_reg) begin
			async_wake_reg <= 1'b0;
		end else if (ctrl_reg.wake_on_low_enable && !ctrl_reg.sync_mode && sleep_mode) begin
			async_wake_reg <= ~async_wake_reg; // R5
		end
	end

	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			async_seen_reg <= 1'b0;
			async_seen_s_reg <= 1'b0;
			async_seen_d_reg <= 1'b0;
		end else begin
			async_seen_reg <= async_wake_reg;
			async_seen_s_reg <= async_seen_reg;
			// Toggle compare uses only settled stages, never the first one
			async_seen_d_reg <= async_seen_s_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake detection; wake-on-low only meaningful in asynchronous mode
	logic wake_armed, wake_hit;
	assign wake_armed = ctrl_reg.wake_on_low_enable & ~ctrl_reg.sync_mode; // R2
	// Clocked edge while awake, or the toggle from the asleep path
	assign wake_hit = wake_armed & ((rx_fall & ~sleep_mode) | (async_seen_s_reg ^ async_seen_d_reg)); // R4 R5 R8

	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			wake_pending_reg <= 1'b0;
			wake_event_reg <= 1'b0;
		end else begin
			wake_event_reg <= wake_hit;
			if (wake_hit) begin
				wake_pending_reg <= 1'b1; // R5
			end else if (rx_rd) begin
				wake_pending_reg <= 1'b0; // R6
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control bits; hardware clears win over software writes
	assign tx_load = tx_full_reg && tx_state_reg == TX_IDLE && ctrl_reg.transmit_enable_bit;
	assign tx_done = tx_state_reg == TX_STOP && baud_tick && tx_tick_cnt_reg == `OVERSAMPLE_LAST;

	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			ctrl_reg <= '0;
			autobaud_start_reg <= 1'b0;
			await_second_reg <= 1'b0;
		end else begin
			autobaud_start_reg <= 1'b0;
			if (ctrl_wr) begin
				ctrl_reg <= ctrl_wr_data;
			end
			if (ctrl_reg.wake_on_low_enable && rx_rise && wake_pending_reg) begin
				ctrl_reg.wake_on_low_enable <= 1'b0; // R7
				await_second_reg <= 1'b1; // R18
				// Measurement deferred to the byte after the break
				autobaud_start_reg <= ctrl_reg.autobaud_enable; // R22
			end
			if (rx_done) begin
				await_second_reg <= 1'b0;
			end
			if (tx_done && tx_is_break_reg) begin
				ctrl_reg.break_send_request <= 1'b0; // R13
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter; one buffered byte behind the shifter
	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			transmit_data_reg <= 8'h00;
			tx_full_reg <= 1'b0;
		end else begin
			if (tx_wr) begin
				transmit_data_reg <= tx_wr_data; // R15
				tx_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_full_reg <= 1'b0; // R16
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			tx_state_reg <= TX_IDLE;
			shift_reg <= 8'h00;
			tx_is_break_reg <= 1'b0;
			tx_tick_cnt_reg <= 4'h0;
			tx_bit_cnt_reg <= 4'h0;
			serial_out_line <= 1'b1;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					serial_out_line <= 1'b1;
					if (tx_load) begin
						// Break ignores written data
						tx_is_break_reg <= ctrl_reg.break_send_request; // R12
						shift_reg <= ctrl_reg.break_send_request ? 8'h00 : transmit_data_reg; // R12
						tx_tick_cnt_reg <= 4'h0;
						tx_state_reg <= TX_START;
					end
				end
				TX_START: begin
					serial_out_line <= 1'b0; // R11
					if (baud_tick) begin
						tx_tick_cnt_reg <= tx_tick_cnt_reg + 4'h1;
						if (tx_tick_cnt_reg == `OVERSAMPLE_LAST) begin
							tx_bit_cnt_reg <= 4'h0;
							tx_state_reg <= TX_DATA;
						end
					end
				end
				TX_DATA: begin
					serial_out_line <= tx_is_break_reg ? 1'b0 : shift_reg[0]; // R11
					if (baud_tick) begin
						tx_tick_cnt_reg <= tx_tick_cnt_reg + 4'h1;
						if (tx_tick_cnt_reg == `OVERSAMPLE_LAST) begin
							shift_reg <= {1'b0, shift_reg[7:1]};
							tx_bit_cnt_reg <= tx_bit_cnt_reg + 4'h1;
							if (tx_bit_cnt_reg == (tx_is_break_reg ? `BREAK_ZERO_BITS : `DATA_BITS) - 4'h1) begin
								tx_state_reg <= TX_STOP; // R11
							end
						end
					end
				end
				TX_STOP: begin
					serial_out_line <= 1'b1;
					if (baud_tick) begin
						tx_tick_cnt_reg <= tx_tick_cnt_reg + 4'h1;
						if (tx_done) begin
							tx_state_reg <= TX_IDLE; // R13
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver; held idle in sleep or while watching for wake
	logic rx_hold;
	assign rx_hold = sleep_mode | ctrl_reg.wake_on_low_enable | ctrl_reg.sync_mode; // R1 R3
	// Stop bit is sampled a full bit after the last data sample
	assign rx_done = rx_state_reg == RX_STOP && baud_tick && rx_tick_cnt_reg == `OVERSAMPLE_LAST;
	assign rx_frame_ok = rx_s2_reg;

	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			rx_state_reg <= RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_tick_cnt_reg <= 4'h0;
			rx_bit_cnt_reg <= 4'h0;
		end else if (rx_hold) begin
			rx_state_reg <= RX_IDLE; // R3
		end else begin
			unique case (rx_state_reg)
				RX_IDLE: begin
					if (rx_fall) begin
						rx_tick_cnt_reg <= 4'h0;
						rx_state_reg <= RX_START;
					end
				end
				RX_START: begin
					if (baud_tick) begin
						rx_tick_cnt_reg <= rx_tick_cnt_reg + 4'h1;
						if (rx_tick_cnt_reg == `SAMPLE_MID) begin
							rx_state_reg <= rx_s2_reg ? RX_IDLE : RX_DATA;
							rx_tick_cnt_reg <= 4'h0;
							rx_bit_cnt_reg <= 4'h0;
						end
					end
				end
				RX_DATA: begin
					if (baud_tick) begin
						rx_tick_cnt_reg <= rx_tick_cnt_reg + 4'h1;
						if (rx_tick_cnt_reg == `OVERSAMPLE_LAST) begin
							rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
							rx_bit_cnt_reg <= rx_bit_cnt_reg + 4'h1;
							if (rx_bit_cnt_reg == `DATA_BITS - 4'h1) begin
								rx_state_reg <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (baud_tick) begin
						rx_tick_cnt_reg <= rx_tick_cnt_reg + 4'h1;
						if (rx_done) begin
							rx_state_reg <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive data and status; a new character wins over a same-cycle read
	always_ff @(posedge ref_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			receive_data_reg <= 8'h00;
			stat_reg <= 6'b00_1110;
		end else begin
			stat_reg.receiver_idle_flag <= rx_state_reg == RX_IDLE;
			stat_reg.shifter_empty_flag <= tx_state_reg == TX_IDLE && !tx_load; // R14
			stat_reg.transmit_buffer_empty_flag <= !tx_full_reg || tx_load; // R16
			if (rx_done && !rx_hold) begin
				receive_data_reg <= rx_shift_reg;
				stat_reg.receive_pending_flag <= 1'b1; // R18
				stat_reg.framing_error_flag <= !rx_frame_ok;
				stat_reg.break_received <= !rx_frame_ok && rx_shift_reg == 8'h00; // R17
			end else if (wake_hit || wake_pending_reg) begin
				stat_reg.receive_pending_flag <= !(rx_rd && !wake_hit); // R5 R6
			end else if (rx_rd) begin
				stat_reg.receive_pending_flag <= 1'b0; // R6
				stat_reg.break_received <= 1'b0;
			end
		end
	end
endmodule

// ---- serial_port_unit_sva.sv ----
`timescale 1ns/100ps
module serial_port_unit_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ctrl_wr,
	input wire logic tx_wr,
	input wire logic rx_rd,
	input wire logic serial_in_line,
	input wire serial_port_pkg::ctrl_t ctrl_reg,
	input wire serial_port_pkg::stat_t stat_reg,
	input wire logic serial_out_line,
	input wire logic wake_event_reg
);
	import serial_port_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_wake_pend; wake_event_reg |-> ##[0:1] stat_reg.receive_pending_flag; endproperty
	a_wake_pend: assert property (p_wake_pend) else $error("wake without pending");
	property p_wake_one; wake_event_reg |=> !wake_event_reg; endproperty
	a_wake_one: assert property (p_wake_one) else $error("wake pulse too long");
	property p_wake_async; ctrl_reg.sync_mode |-> !wake_event_reg; endproperty
	a_wake_async: assert property (p_wake_async) else $error("wake in sync mode");
	property p_rx_hold; ctrl_reg.wake_on_low_enable |-> stat_reg.receiver_idle_flag; endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("reception while waiting");
	// A wake in the read's own cycle wins over it; reads during or one cycle after a wake pulse are not checked
	property p_rd_clr; rx_rd && !wake_event_reg && !$past(wake_event_reg)
		&& stat_reg.receiver_idle_flag |=> !stat_reg.receive_pending_flag; endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read left pending");
	property p_tx_busy; !serial_out_line |-> !stat_reg.shifter_empty_flag; endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("idle while sending");
	property p_brk_go; ctrl_reg.break_send_request && ctrl_reg.transmit_enable_bit && tx_wr
		&& stat_reg.shifter_empty_flag |=> ##1 !stat_reg.shifter_empty_flag; endproperty
	a_brk_go: assert property (p_brk_go) else $error("break not started");
	property p_brk_clr; $fell(ctrl_reg.break_send_request) && !$past(ctrl_wr)
		|-> $past(serial_out_line); endproperty
	a_brk_clr: assert property (p_brk_clr) else $error("break cleared early");
	property p_wake_clr; $fell(ctrl_reg.wake_on_low_enable) && !$past(ctrl_wr)
		|-> serial_in_line; endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake cleared while low");
endmodule
bind serial_port_unit serial_port_unit_sva i_sva (.ref_clk, .nrst, .ctrl_wr, .tx_wr,
	.rx_rd, .serial_in_line, .ctrl_reg, .stat_reg, .serial_out_line, .wake_event_reg);

// ---- remote_node.sv ----
`timescale 1ns/100ps
module remote_node (
	input wire logic ref_clk,
	input wire logic baud_tick,
	output logic serial_in_line
);
	initial serial_in_line = 1'b1;
	// Only all-zero frames: a non-zero wake byte would leave a fragment behind
	task automatic send_low(input int bits);
		serial_in_line <= 1'b0;
		repeat (bits * 16) @(posedge ref_clk iff baud_tick);
		serial_in_line <= 1'b1;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
	import serial_port_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic baud_tick = 1'b0;
	logic sleep_mode = 1'b0;
	logic serial_in_line;
	ctrl_t ctrl_wr_data = ctrl_t'(5'h00);
	logic ctrl_wr = 1'b0;
	logic [7:0] tx_wr_data = 8'h00;
	logic tx_wr = 1'b0;
	logic rx_rd = 1'b0;
	logic [7:0] receive_data_reg;
	ctrl_t ctrl_reg;
	stat_t stat_reg;
	logic serial_out_line;
	logic wake_event_reg;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	serial_port_unit i_dut (.ref_clk, .nrst, .baud_tick, .sleep_mode, .serial_in_line,
		.ctrl_wr_data, .ctrl_wr, .tx_wr_data, .tx_wr, .rx_rd, .receive_data_reg, .ctrl_reg,
		.stat_reg, .serial_out_line, .wake_event_reg, .autobaud_start_reg());
	remote_node u_node (.ref_clk, .baud_tick, .serial_in_line);
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Tick every other clock, so one bit lasts 32 clocks
	always @(posedge ref_clk) begin
		baud_tick <= ~baud_tick;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic set_ctrl(input ctrl_t c);
		@(posedge ref_clk);
		ctrl_wr_data <= c;
		ctrl_wr <= 1'b1;
		@(posedge ref_clk);
		ctrl_wr <= 1'b0;
	endtask
	task automatic wr_tx(input logic [7:0] d);
		repeat (2) @(posedge ref_clk);
		while (stat_reg.transmit_buffer_empty_flag !== 1'b1) @(posedge ref_clk);
		tx_wr_data <= d;
		tx_wr <= 1'b1;
		@(posedge ref_clk);
		tx_wr <= 1'b0;
	endtask
	task automatic rd_clear;
		@(posedge ref_clk);
		rx_rd <= 1'b1;
		@(posedge ref_clk);
		rx_rd <= 1'b0;
		@(posedge ref_clk);
		cmp(8'(stat_reg.receive_pending_flag), 8'h00);
	endtask
	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_rx_break;
		u_node.send_low(10);
		repeat (8) @(posedge ref_clk);
		cmp(8'({stat_reg.receive_pending_flag, stat_reg.framing_error_flag,
			stat_reg.break_received}), 8'h07);
		cmp(receive_data_reg, 8'h00);
		rd_clear();
	endtask
	task automatic t_wake(input logic s);
		sleep_mode <= s;
		cmp(8'(stat_reg.receiver_idle_flag), 8'h01);
		set_ctrl(ctrl_t'(5'h10));
		u_node.send_low(13);
		repeat (8) @(posedge ref_clk);
		sleep_mode <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cmp(8'({stat_reg.receive_pending_flag, ctrl_reg.wake_on_low_enable}), 8'h02);
		rd_clear();
	endtask
	task automatic t_hold(input ctrl_t c, input logic s);
		sleep_mode <= s;
		set_ctrl(c);
		u_node.send_low(10);
		repeat (8) @(posedge ref_clk);
		cmp(8'(stat_reg.receive_pending_flag), 8'h00);
		sleep_mode <= 1'b0;
		set_ctrl(ctrl_t'(5'h00));
	endtask
	task automatic t_break;
		int n;
		logic [7:0] b;
		n = 0;
		set_ctrl(ctrl_t'(5'h03));
		wr_tx(8'hA5);
		fork
			wr_tx(8'h55);
			begin
				while (serial_out_line === 1'b1) @(posedge ref_clk);
				while (serial_out_line === 1'b0) begin
					@(posedge ref_clk);
					n++;
				end
			end
		join
		cmp(8'((n + 16) / 32), 8'h0D);
		while (serial_out_line === 1'b1) @(posedge ref_clk);
		repeat (48) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			b[i] = serial_out_line;
			repeat (32) @(posedge ref_clk);
		end
		cmp(b, 8'h55);
		cmp(8'(ctrl_reg.break_send_request), 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		cmp(8'(stat_reg), 8'h0E);
		cmp(8'({serial_out_line, ctrl_reg}), 8'h20);
		t_rx_break();
		t_wake(1'b0);
		t_wake(1'b1);
		t_hold(ctrl_t'(5'h14), 1'b0);
		t_hold(ctrl_t'(5'h00), 1'b1);
		t_break();
		end_of_test();
	end
endmodule
